/* logic/dht_timer.sv */
// dual half general timer with register port, capture pins and seconds clock
//
// The placing of the registers and strobed register access were decided locally.
module dht_timer #(
  parameter int RTC_DIV = dht_pkg::RTC_DIV_DEF
) (
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  input wire logic [dht_pkg::ADDR_W-1:0] ADDR_I,
  input wire logic [dht_pkg::DATA_W-1:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [dht_pkg::DATA_W-1:0] RDATA_O,
  input wire logic DBG_HALT_I,
  input wire logic RTC_CLK_I,
  input wire logic [1:0] CAP_PIN_I,
  output logic [1:0] CAP_PIN_O,
  output logic [1:0] CAP_PIN_OE_O,
  output logic [1:0] TRIG_O,
  output logic IRQ_O
);
  import dht_pkg::*;

  localparam logic [DIV_W-1:0] RTC_LAST = DIV_W'(RTC_DIV - 1);

  dht_state_s s;
  dht_state_s next_s;

  // edge selection on the two synchronised samples
  function automatic logic edge_hit(input logic [1:0] sel, input logic now, input logic old);
    logic rise;
    logic fall;
    rise = now & ~old;
    fall = ~now & old;
    unique case (sel)
      EDGE_RISE: edge_hit = rise;
      EDGE_FALL: edge_hit = fall;
      EDGE_BOTH: edge_hit = rise | fall;
      default: edge_hit = 1'b0;
    endcase
  endfunction

  // status bit index of a source for a half
  function automatic int irq_bit(input int h, input int base);
    irq_bit = base + h * IRQ_HALF_STEP;
  endfunction

  // next state of the whole block
  always_comb begin
    logic split;
    logic [1:0] run;
    logic [1:0] tick;
    logic [1:0] ev;
    logic [HALF_W-1:0] dec;
    logic [31:0] wide;
    logic [31:0] wide_load;
    logic [31:0] wide_mtch;
    logic rtc_edge;
    logic [1:0] load_wr;
    split = 1'b0;
    run = '0;
    tick = '0;
    ev = '0;
    dec = '0;
    wide = '0;
    wide_load = '0;
    wide_mtch = '0;
    rtc_edge = 1'b0;
    load_wr = '0;
    next_s = s;
    next_s.trig = '0;
    next_s.rdata = '0;

    // three stage pin synchronisers, only stages two and three are looked at
    for (int h = 0; h < 2; h++) begin
      next_s.sync[h] = {s.sync[h][1:0], CAP_PIN_I[h]};
    end
    next_s.rsync = {s.rsync[1:0], RTC_CLK_I};
    rtc_edge = s.rsync[1] & ~s.rsync[2];

    // register writes
    if (WR_I) begin
      unique case (ADDR_I)
        // reconfiguring always leaves both halves stopped
        REG_CFG: begin
          next_s.wmode = dht_wide_e'(WDATA_I[CFG_WIDE_LSB +: 2]);
          for (int h = 0; h < 2; h++) begin
            next_s.hmode[h] = dht_half_e'(WDATA_I[CFG_HALF_LSB + h * CFG_HALF_STEP +: 3]);
          end
          next_s.en = '0;
          next_s.lvl = '0;
          next_s.rdiv = '0;
        end
        REG_CTRL: begin
          next_s.en = WDATA_I[CTRL_EN_LSB +: 2];
          next_s.pol = WDATA_I[CTRL_POL_LSB +: 2];
          next_s.frz = WDATA_I[CTRL_FRZ_LSB +: 2];
          next_s.trg = WDATA_I[CTRL_TRG_LSB +: 2];
          for (int h = 0; h < 2; h++) begin
            next_s.edg[h] = WDATA_I[CTRL_EDGE_LSB + h * CTRL_EDGE_STEP +: 2];
          end
        end
        // joined modes take the whole word into both halves
        REG_LOAD_A: begin
          if (s.wmode == HALVES_SPLIT) begin
            next_s.load[0] = WDATA_I[HALF_W-1:0];
            load_wr = 2'b01;
          end else begin
            next_s.load = WDATA_I;
            load_wr = 2'b11;
          end
        end
        REG_LOAD_B: begin
          next_s.load[1] = WDATA_I[HALF_W-1:0];
          load_wr = 2'b10;
        end
        // match follows the same split or joined layout as load
        REG_MATCH_A: begin
          if (s.wmode == HALVES_SPLIT) begin
            next_s.mtch[0] = WDATA_I[HALF_W-1:0];
          end else begin
            next_s.mtch = WDATA_I;
          end
        end
        REG_MATCH_B: next_s.mtch[1] = WDATA_I[HALF_W-1:0];
        REG_PRESCALE: begin
          next_s.psc[0] = WDATA_I[0 +: PSC_W];
          next_s.psc[1] = WDATA_I[PSC_STEP +: PSC_W];
        end
        // write one to clear, a source set in the same cycle still wins below
        REG_IRQ_RAW: next_s.irq_raw = s.irq_raw & ~WDATA_I[IRQ_W-1:0];
        REG_IRQ_MASK: next_s.irq_mask = WDATA_I[IRQ_W-1:0];
        default: ;
      endcase
    end

    // run gate per half and pin events from stages two and three
    split = (s.wmode == HALVES_SPLIT);
    for (int h = 0; h < 2; h++) begin
      run[h] = s.en[h] & ~(s.frz[h] & DBG_HALT_I);
      ev[h] = edge_hit(s.edg[h], s.sync[h][1], s.sync[h][2]);
    end

    if (split) begin
      // independent halves with prescaler
      for (int h = 0; h < 2; h++) begin
        if (run[h]) begin
          next_s.pcnt[h] = (s.pcnt[h] == '0) ? s.psc[h] : s.pcnt[h] - 1'b1;
          tick[h] = (s.pcnt[h] == '0);
        end
        dec = s.cnt[h] - 1'b1;
        unique case (s.hmode[h])
          HALF_SINGLE_RUN, HALF_REPEATING: begin
            if (tick[h]) begin
              if (s.cnt[h] == '0) begin
                next_s.irq_raw[irq_bit(h, IRQ_TMO)] = 1'b1;
                next_s.trig[h] = s.trg[h];
                if (s.hmode[h] == HALF_REPEATING) begin
                  next_s.cnt[h] = s.load[h];
                end else begin
                  next_s.en[h] = 1'b0;
                end
              end else begin
                next_s.cnt[h] = dec;
              end
            end
          end
          // tally counts down per event and stops at the match value
          HALF_EDGE_TALLY: begin
            if (run[h] && ev[h]) begin
              next_s.cnt[h] = dec;
              next_s.irq_raw[irq_bit(h, IRQ_CEV)] = 1'b1;
              if (dec == s.mtch[h]) begin
                next_s.irq_raw[irq_bit(h, IRQ_CMT)] = 1'b1;
                next_s.trig[h] = s.trg[h];
                next_s.en[h] = 1'b0;
              end
            end
          end
          // timestamp free runs and latches the count on each event
          HALF_EDGE_TIMESTAMP: begin
            if (tick[h]) begin
              next_s.cnt[h] = (s.cnt[h] == '0) ? s.load[h] : dec;
            end
            if (run[h] && ev[h]) begin
              next_s.capt[h] = s.cnt[h];
              next_s.irq_raw[irq_bit(h, IRQ_CEV)] = 1'b1;
            end
          end
          // level rises at reload and falls when the count meets match
          HALF_PULSE: begin
            if (tick[h]) begin
              if (s.cnt[h] == '0) begin
                next_s.cnt[h] = s.load[h];
                next_s.lvl[h] = 1'b1;
                next_s.trig[h] = s.trg[h];
              end else begin
                next_s.cnt[h] = dec;
                if (dec == s.mtch[h]) begin
                  next_s.lvl[h] = 1'b0;
                end
              end
            end
          end
          // unused mode codes park the half
          default: begin
            next_s.en[h] = 1'b0;
          end
        endcase
      end
    end else begin
      // joined halves, first half controls the pair
      wide = {s.cnt[1], s.cnt[0]};
      wide_load = {s.load[1], s.load[0]};
      wide_mtch = {s.mtch[1], s.mtch[0]};
      if (run[0]) begin
        unique case (s.wmode)
          WIDE_SINGLE_RUN, WIDE_REPEATING: begin
            if (wide == '0) begin
              next_s.irq_raw[IRQ_TMO] = 1'b1;
              next_s.trig[0] = s.trg[0];
              if (s.wmode == WIDE_REPEATING) begin
                wide = wide_load;
              end else begin
                next_s.en[0] = 1'b0;
              end
            end else begin
              wide = wide - 1'b1;
            end
          end
          // counts up once per divided seconds input period
          WIDE_SECONDS: begin
            if (rtc_edge) begin
              if (s.rdiv == RTC_LAST) begin
                next_s.rdiv = '0;
                wide = wide + 1'b1;
                if (wide == wide_mtch) begin
                  next_s.irq_raw[IRQ_RTC] = 1'b1;
                  next_s.trig[0] = s.trg[0];
                end
              end else begin
                next_s.rdiv = s.rdiv + 1'b1;
              end
            end
          end
          default: ;
        endcase
      end
      next_s.cnt = wide;
    end

    // interval load overrides the counter even while running
    for (int h = 0; h < 2; h++) begin
      if (load_wr[h]) begin
        next_s.cnt[h] = next_s.load[h];
        next_s.pcnt[h] = next_s.psc[h];
      end
    end

    // capture pins drive only in pulse mode
    for (int h = 0; h < 2; h++) begin
      next_s.oe[h] = split && (s.hmode[h] == HALF_PULSE);
      next_s.pin[h] = next_s.oe[h] & (next_s.lvl[h] ^ s.pol[h]);
    end

    // line follows the updated status so a clear drops it at once
    next_s.irq = |(next_s.irq_raw & next_s.irq_mask);

    // read data, valid in the cycle after the strobe
    if (RD_I) begin
      unique case (ADDR_I)
        REG_CFG: begin
          next_s.rdata[CFG_WIDE_LSB +: 2] = s.wmode;
          for (int h = 0; h < 2; h++) begin
            next_s.rdata[CFG_HALF_LSB + h * CFG_HALF_STEP +: 3] = s.hmode[h];
          end
        end
        REG_CTRL: begin
          next_s.rdata[CTRL_EN_LSB +: 2] = s.en;
          next_s.rdata[CTRL_POL_LSB +: 2] = s.pol;
          next_s.rdata[CTRL_FRZ_LSB +: 2] = s.frz;
          next_s.rdata[CTRL_TRG_LSB +: 2] = s.trg;
          for (int h = 0; h < 2; h++) begin
            next_s.rdata[CTRL_EDGE_LSB + h * CTRL_EDGE_STEP +: 2] = s.edg[h];
          end
        end
        REG_LOAD_A: next_s.rdata = split ? {16'h0000, s.load[0]} : s.load;
        REG_LOAD_B: next_s.rdata[HALF_W-1:0] = s.load[1];
        REG_MATCH_A: next_s.rdata = split ? {16'h0000, s.mtch[0]} : s.mtch;
        REG_MATCH_B: next_s.rdata[HALF_W-1:0] = s.mtch[1];
        REG_PRESCALE: begin
          next_s.rdata[0 +: PSC_W] = s.psc[0];
          next_s.rdata[PSC_STEP +: PSC_W] = s.psc[1];
        end
        REG_VALUE_A: next_s.rdata = split ? {16'h0000, s.cnt[0]} : s.cnt;
        REG_VALUE_B: next_s.rdata[HALF_W-1:0] = s.cnt[1];
        REG_IRQ_RAW: next_s.rdata[IRQ_W-1:0] = s.irq_raw;
        REG_IRQ_MASK: next_s.rdata[IRQ_W-1:0] = s.irq_mask;
        REG_CAPTURE: begin
          next_s.rdata[0 +: HALF_W] = s.capt[0];
          next_s.rdata[CAPT_STEP +: HALF_W] = s.capt[1];
        end
        default: next_s.rdata = '0;
      endcase
    end
  end

  // state register
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      // split halves, all stopped, all masks closed
      s <= '0;
      s.wmode <= HALVES_SPLIT;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from the state register
  assign RDATA_O = s.rdata;
  assign CAP_PIN_O = s.pin;
  assign CAP_PIN_OE_O = s.oe;
  assign TRIG_O = s.trig;
  assign IRQ_O = s.irq;
endmodule

/* logic/dht_pkg.sv */
// shared constants, register map and state types of the dual half timer
package dht_pkg;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 32;
  localparam int HALF_W = 16;
  localparam int PSC_W = 8;
  localparam int DIV_W = 16;
  localparam int IRQ_W = 11;
  // word aligned register byte offsets
  localparam logic [5:0] REG_CFG = 6'h00;
  localparam logic [5:0] REG_CTRL = 6'h04;
  localparam logic [5:0] REG_LOAD_A = 6'h08;
  localparam logic [5:0] REG_LOAD_B = 6'h0c;
  localparam logic [5:0] REG_MATCH_A = 6'h10;
  localparam logic [5:0] REG_MATCH_B = 6'h14;
  localparam logic [5:0] REG_PRESCALE = 6'h18;
  localparam logic [5:0] REG_VALUE_A = 6'h1c;
  localparam logic [5:0] REG_VALUE_B = 6'h20;
  localparam logic [5:0] REG_IRQ_RAW = 6'h24;
  localparam logic [5:0] REG_IRQ_MASK = 6'h28;
  localparam logic [5:0] REG_CAPTURE = 6'h2c;
  // configuration fields
  localparam int CFG_WIDE_LSB = 0;
  localparam int CFG_HALF_LSB = 2;
  localparam int CFG_HALF_STEP = 3;
  // control fields, one bit per half except the edge selects, two bits per half
  localparam int CTRL_EN_LSB = 0;
  localparam int CTRL_POL_LSB = 2;
  localparam int CTRL_FRZ_LSB = 4;
  localparam int CTRL_TRG_LSB = 6;
  localparam int CTRL_EDGE_LSB = 8;
  localparam int CTRL_EDGE_STEP = 2;
  // prescale and capture fields per half
  localparam int PSC_STEP = 8;
  localparam int CAPT_STEP = 16;
  // interrupt status bits, second half sits one step higher
  localparam int IRQ_TMO = 0;
  localparam int IRQ_CEV = 1;
  localparam int IRQ_CMT = 2;
  localparam int IRQ_RTC = 3;
  localparam int IRQ_HALF_STEP = 8;
  // seconds clock input rate and seconds per count
  localparam int RTC_IN_HZ = 32768;
  localparam int RTC_SEC = 1;
  localparam int RTC_DIV_DEF = RTC_IN_HZ * RTC_SEC;
  localparam logic [1:0] EDGE_RISE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h2;

  typedef enum logic [1:0] {
    WIDE_SINGLE_RUN = 2'h0,
    WIDE_REPEATING = 2'h1,
    WIDE_SECONDS = 2'h2,
    HALVES_SPLIT = 2'h3
  } dht_wide_e;

  typedef enum logic [2:0] {
    HALF_SINGLE_RUN = 3'h0,
    HALF_REPEATING = 3'h1,
    HALF_EDGE_TALLY = 3'h2,
    HALF_EDGE_TIMESTAMP = 3'h3,
    HALF_PULSE = 3'h4
  } dht_half_e;

  typedef struct packed {
    dht_wide_e wmode;
    dht_half_e [1:0] hmode;
    logic [1:0] en;
    logic [1:0] pol;
    logic [1:0] frz;
    logic [1:0] trg;
    logic [1:0][1:0] edg;
    logic [1:0][HALF_W-1:0] load;
    logic [1:0][HALF_W-1:0] mtch;
    logic [1:0][HALF_W-1:0] cnt;
    logic [1:0][HALF_W-1:0] capt;
    logic [1:0][PSC_W-1:0] psc;
    logic [1:0][PSC_W-1:0] pcnt;
    logic [1:0][2:0] sync;
    logic [2:0] rsync;
    logic [DIV_W-1:0] rdiv;
    logic [1:0] lvl;
    logic [IRQ_W-1:0] irq_raw;
    logic [IRQ_W-1:0] irq_mask;
    logic irq;
    logic [1:0] trig;
    logic [1:0] pin;
    logic [1:0] oe;
    logic [DATA_W-1:0] rdata;
  } dht_state_s;
endpackage

/* verif/dht_timer_chk.sv */
// port assertions for the dual half timer
module dht_timer_chk
  import dht_pkg::*;
(
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  input wire logic [dht_pkg::ADDR_W-1:0] ADDR_I,
  input wire logic [dht_pkg::DATA_W-1:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [dht_pkg::DATA_W-1:0] RDATA_O,
  input wire logic [1:0] CAP_PIN_OE_O,
  input wire logic [1:0] TRIG_O,
  input wire logic IRQ_O
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dcb @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);
  // decoded register strobes
  wire logic cfg_wr = WR_I && ADDR_I == REG_CFG;
  wire logic ctl_wr = WR_I && ADDR_I == REG_CTRL;
  wire logic clr_wr = WR_I && (ADDR_I == REG_IRQ_RAW || ADDR_I == REG_IRQ_MASK);
  wire logic msk_off = WR_I && ADDR_I == REG_IRQ_MASK && WDATA_I[IRQ_W-1:0] == '0;
  // configuration write, then no enable for four cycles
  sequence s_cfg_quiet;
    cfg_wr ##1 !ctl_wr [*4];
  endsequence
  // configuration write, then no other one
  sequence s_cfg_pulse;
    cfg_wr && WDATA_I[1:0] == 2'h3 && WDATA_I[4:2] == 3'h4 ##1 !cfg_wr;
  endsequence
  sequence s_cfg_wide;
    cfg_wr && WDATA_I[1:0] != 2'h3 ##1 !cfg_wr;
  endsequence
  a_read_idle: assert property (!RD_I |=> RDATA_O == '0)
    else $error("read data not zero outside answer cycle");
  a_unmapped_rd: assert property (RD_I && ADDR_I > REG_CAPTURE |=> RDATA_O == '0)
    else $error("unmapped read returned data");
  a_cfg_stops: assert property (s_cfg_quiet |-> TRIG_O == 2'h0)
    else $error("trigger after configuration without enable");
  a_irq_hold: assert property (IRQ_O && !clr_wr && !$past(clr_wr) |=> IRQ_O)
    else $error("interrupt dropped without clear");
  a_mask_off: assert property (msk_off ##1 !clr_wr |=> !IRQ_O)
    else $error("interrupt with all sources masked");
  a_oe_wide: assert property (s_cfg_wide |=> CAP_PIN_OE_O == 2'h0)
    else $error("pin driven in joined mode");
  a_oe_pulse: assert property (s_cfg_pulse |=> CAP_PIN_OE_O[0])
    else $error("pin not driven in pulse mode");
  a_oe_cause: assert property ($changed(CAP_PIN_OE_O) |-> $past(cfg_wr) || $past(cfg_wr, 2))
    else $error("pin enable changed without configuration");
endmodule

bind dht_timer dht_timer_chk u_chk (.REF_CLK_I, .RST_I, .ADDR_I, .WDATA_I, .WR_I, .RD_I,
  .RDATA_O, .CAP_PIN_OE_O, .TRIG_O, .IRQ_O);

/* verif/dht_pin_src.sv */
// outside logic driving capture pins and the seconds clock
module dht_pin_src (
  output logic [1:0] pin_o,
  output logic rtc_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle levels
  initial begin
    pin_o = 2'h0;
    rtc_o = 1'b0;
  end
  // whole pulses, each level held past the synchronizer
  task automatic pulse(input int h, input int n);
    repeat (n) begin
      #160 pin_o[h] = 1'b1;
      #160 pin_o[h] = 1'b0;
    end
  endtask
  // seconds clock edges, still between bursts
  task automatic rtc(input int n);
    repeat (n) begin
      #137 rtc_o = 1'b1;
      #137 rtc_o = 1'b0;
    end
  endtask
endmodule

/* verif/dht_timer_test.sv */
// self-checking bench for the dual half timer
module dht_timer_test;
  timeunit 1ns;
  timeprecision 1ps;
  import dht_pkg::*;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, dbg = 1'b0, rd_d = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0, rdata;
  logic [1:0] pin, pin_o, oe, trig;
  logic rtc, irq;
  logic [31:0] seed = 32'hf351;
  logic [DATA_W-1:0] exp_q[$];
  int fail_count = 0, checks_done = 0, ntrig = 0, nhigh = 0;
  // clock
  always #12.5 clk = ~clk;
  dht_timer #(.RTC_DIV(4)) u_dut (.REF_CLK_I(clk), .RST_I(rst), .ADDR_I(addr),
    .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .DBG_HALT_I(dbg),
    .RTC_CLK_I(rtc), .CAP_PIN_I((oe & pin_o) | (~oe & pin)), .CAP_PIN_O(pin_o),
    .CAP_PIN_OE_O(oe), .TRIG_O(trig), .IRQ_O(irq));
  dht_pin_src u_src (.pin_o(pin), .rtc_o(rtc));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // trigger and pulse statistics, read answers off the queue
  always @(posedge clk) begin
    rd_d <= rd;
    ntrig <= ntrig + trig[0] + trig[1];
    nhigh <= nhigh + pin_o[0];
  end
  always @(negedge clk) if (rd_d) chk("rdata", exp_q.pop_front(), rdata);
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic logic [5:0] off(input int h);
    return h ? 6'h04 : 6'h00;
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr_reg(input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [5:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
  endtask
  // configure first, then enable
  task automatic setup(input int h, input logic [31:0] c, ld, mt, ps, ct);
    wr_reg(REG_CFG, c);
    wr_reg(REG_IRQ_RAW, 32'h7ff);
    wr_reg(REG_PRESCALE, ps);
    wr_reg(REG_LOAD_A + off(h), ld);
    wr_reg(REG_MATCH_A + off(h), mt);
    wr_reg(REG_CTRL, ct);
  endtask
  // watchdog
  initial begin
    tick(20000);
    fail_count++;
    print_verdict();
  end
  // main sequence
  initial begin
    logic [31:0] v;
    int n;
    tick(16);
    rst <= 1'b0;
    rd_reg(REG_CFG, 32'h3);
    rd_reg(REG_IRQ_MASK, 32'h0);
    rd_reg(6'h30, 32'h0);
    $display("test reset done");
    for (int h = 0; h < 2; h++) begin
      for (int t = 0; t < 2; t++) begin
        setup(h, 32'h3, 32'h2, 32'h0, 32'h0, (32'h1 | (t << 6)) << h);
        n = ntrig;
        tick(20);
        chk("trig count", t, ntrig - n);
        rd_reg(REG_IRQ_RAW, 32'h1 << (8 * h));
        rd_reg(REG_VALUE_A + off(h), 32'h0);
      end
    end
    // joined single run: one timeout, then stopped at zero
    setup(0, 32'h0, 32'h2, 32'h0, 32'h0, 32'h41);
    n = ntrig;
    tick(20);
    chk("wide trig count", 1, ntrig - n);
    rd_reg(REG_IRQ_RAW, 32'h1);
    rd_reg(REG_VALUE_A, 32'h0);
    $display("test single done");
    for (int p = 0; p < 3; p++) begin
      setup(0, p == 2 ? 32'h1 : 32'h7, 32'h3, 32'h0, p == 0 ? 0 : 1, 32'h41);
      n = ntrig;
      tick(80);
      n = ntrig - n;
      v = p == 1 ? 10 : 20;
      chk("repeat count", 1, n >= v - 1 && n <= v);
    end
    $display("test repeat done");
    setup(0, 32'h7, 32'hffff, 32'h0, 32'h7, 32'h1);
    tick(30);
    seed = xs(seed);
    v = {16'h0, 1'b1, seed[14:0]};
    wr_reg(REG_LOAD_A, v);
    rd_reg(REG_VALUE_A, v);
    dbg <= 1'b1;
    wr_reg(REG_CTRL, 32'h11);
    seed = xs(seed);
    v = {16'h0, 1'b1, seed[14:0]};
    wr_reg(REG_LOAD_A, v);
    tick(40);
    rd_reg(REG_VALUE_A, v);
    dbg <= 1'b0;
    $display("test load done");
    for (int h = 0; h < 2; h++) begin
      for (int e = 0; e < 3; e++) begin
        setup(h, 32'h3 | (32'h2 << (2 + 3 * h)), 32'ha, 32'h5, 32'h0,
          (32'h1 << h) | (e << (8 + 2 * h)));
        u_src.pulse(h, 3);
        tick(10);
        rd_reg(REG_VALUE_A + off(h), e == 2 ? 32'h5 : 32'h7);
        rd_reg(REG_IRQ_RAW, (e == 2 ? 32'h6 : 32'h2) << (8 * h));
      end
    end
    setup(0, 32'hf, 32'hffff, 32'h0, 32'h0, 32'h1);
    u_src.pulse(0, 1);
    tick(10);
    rd_reg(REG_IRQ_RAW, 32'h2);
    // rise lands 6.4 cycles after enable, seen on stage three 3 edges later
    rd_reg(REG_CAPTURE, 32'h0000fff7);
    $display("test capture done");
    setup(0, 32'h2, 32'h0, 32'h2, 32'h0, 32'h1);
    wr_reg(REG_IRQ_MASK, 32'h8);
    u_src.rtc(8);
    tick(8);
    rd_reg(REG_VALUE_A, 32'h2);
    rd_reg(REG_IRQ_RAW, 32'h8);
    u_src.rtc(4);
    tick(8);
    chk("irq", 1, irq);
    wr_reg(REG_IRQ_MASK, 32'h0);
    tick(3);
    chk("irq", 0, irq);
    wr_reg(REG_IRQ_RAW, 32'h8);
    rd_reg(REG_IRQ_RAW, 32'h0);
    $display("test seconds done");
    for (int q = 0; q < 2; q++) begin
      setup(0, 32'h13, 32'h7, 32'h5, 32'h0, 32'h1 | (q << 2));
      tick(8);
      n = nhigh;
      tick(80);
      n = nhigh - n;
      v = q ? 60 : 20;
      chk("pin enable", 1, oe[0]);
      chk("duty", 1, n >= v - 2 && n <= v + 2);
    end
    $display("test pulse done");
    tick(4);
    print_verdict();
  end
endmodule
